// ===== common/scu_pkg.sv
// Contract
// - I2C clock falling edge sets written flag
// - Buffer read clears written flag, never lost
// - Status bit shows clock line held low
// - SPI busy falls after transfer, stays low
// - Clock request follows busy, drops when idle
// - Ready flags: transmit empty, character received
// - Transmit complete only when buffer is empty
// - Clock idles at polarity level at release
// - Slave fills buffer, shifts correct first bit
// - Enable mode picks pin input or output in SPI master mode
package scu_pkg;

  // Character width on every path
  localparam int BYTE_W = 8;
  // I2C rise counter: last data bit and acknowledge bit
  localparam logic [3:0] I2C_LAST_DATA = 4'h7;
  localparam logic [3:0] I2C_ACK_RISE = 4'h8;
  localparam logic [3:0] I2C_COUNT_RESET = 4'h0;
  // Data reset values
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] BIT_RESET = 3'h0;
  // Last bit index within a character
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Control bits from software
  typedef struct packed {
    logic i2cMode;              // 1: I2C, 0: SPI
    logic masterMode;           // SPI master when set
    logic clockPolaritySelect;  // Idle level of the SPI clock
    logic clockPhaseSelect;     // 0: sample leading edge
    logic slaveEnableMode;      // 0: enable pin is input, 1: output in SPI master mode only
    logic softResetBit;         // Holds the unit in reset
  } scu_ctrl_t;

  // Status bits to software
  typedef struct packed {
    logic unitBusyFlag;
    logic transmitReadyFlag;
    logic receiveReadyFlag;
    logic transmitCompleteFlag;
    logic clockHeldLowStatus;
    logic overflowFlag;
  } scu_status_t;

endpackage

// ===== logic/scu_link.sv
`timescale 1ns/1ps
// SPI slave shifter, clocked by the peer's serial clock
module scu_link (
  input wire logic linkClock,
  input wire logic linkReset,
  input wire logic clockPolaritySelect,
  input wire logic clockPhaseSelect,
  input wire logic mosi,
  input wire logic [scu_pkg::BYTE_W-1:0] txWord,
  output logic [scu_pkg::BYTE_W-1:0] rxWord,
  output logic rxToggle,
  output logic misoBit
);
  import scu_pkg::*;

  // Sampling clock: its rising edge is always the sampling edge
  logic sampleClk;
  // Bits sampled and bits shifted in the current character
  logic [2:0] sampleCount;
  logic [2:0] shiftCount;
  logic [BYTE_W-2:0] rxShift;
  // Index of the bit now on the output
  logic [2:0] bitIndex;

  // Mode bits change only while the link is held in reset
  assign sampleClk = linkClock ^ (clockPolaritySelect ^ clockPhaseSelect);

  // Sample on the sampling edge; a full character toggles the event
  always_ff @(posedge sampleClk or posedge linkReset)
  begin
    if (linkReset)
    begin
      sampleCount <= BIT_RESET;
      rxShift <= '0;
      rxWord <= BYTE_RESET;
      rxToggle <= 1'b0;
    end
    else
    begin
      rxShift <= {rxShift[BYTE_W-3:0], mosi};
      sampleCount <= sampleCount + 3'h1;
      if (sampleCount == LAST_BIT)
      begin
        // Word stays stable a whole character for the other domain
        rxWord <= {rxShift, mosi};
        rxToggle <= ~rxToggle;
      end
    end
  end

  // Advance the output bit on the shifting edge
  always_ff @(negedge sampleClk or posedge linkReset)
  begin
    if (linkReset)
      shiftCount <= BIT_RESET;
    else
      shiftCount <= shiftCount + 3'h1;
  end

  // Phase 1 shifts before its first sample, so index lags one edge.
  // Correct only if the clock sat at its idle level at release.
  assign bitIndex = clockPhaseSelect ? shiftCount - 3'h1 : shiftCount;
  // MSB first; phase 0 presents bit 7 before the first edge
  assign misoBit = txWord[LAST_BIT - bitIndex];

endmodule // scu_link

// ===== logic/scu_top.sv
`timescale 1ns/1ps
// Serial unit: SPI slave data path, I2C receive with overflow stall,
// transmit buffering and slave-enable pin handling
module scu_top (
  input wire logic clock,
  input wire logic resetn,
  input wire scu_pkg::scu_ctrl_t ctrl,
  input wire logic [scu_pkg::BYTE_W-1:0] transmitBuffer,
  input wire logic txWrite,
  input wire logic rxRead,
  output scu_pkg::scu_status_t status,
  output logic [scu_pkg::BYTE_W-1:0] receiveBuffer,
  output logic clockRequest,
  input wire logic linkClock,
  input wire logic mosiPin,
  output logic misoPin,
  output logic misoPinOe,
  input wire logic slaveEnablePinIn,
  output logic slaveEnablePinOut,
  output logic slaveEnablePinOe,
  input wire logic sclPinIn,
  input wire logic sdaPinIn,
  output logic sclPinOut,
  output logic sclPinOe
);
  import scu_pkg::*;

  // Synchronisers; stage 0 is read only by stage 1
  logic [2:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] steSync;
  logic [2:0] rxTogSync;
  // Decoded events
  logic sclRise, sclFall, sdaBit, steActive, spiByteDone, spiMode, masterBlocked;
  logic unitReset;
  // Transmit path
  logic unitBusy, txPending, txReady, txComplete, txIdle;
  logic [BYTE_W-1:0] txActive, txHold;
  // Receive path
  logic rxReady, overflow, rxWritten, clearReplay, setWritten;
  logic loadPending, stretchReq, holdLow;
  logic [3:0] i2cCount;
  logic [BYTE_W-1:0] i2cShift, i2cByte;
  // Link side
  logic linkReset, linkRxToggle, linkMiso;
  logic [BYTE_W-1:0] linkRxWord;

  // The I2C pins, the enable pin and the link event cross through two flops first
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      sclSync <= 3'h7;
      sdaSync <= 2'h3;
      steSync <= 2'h3;
      rxTogSync <= 3'h0;
    end
    else
    begin
      sclSync <= {sclSync[1:0], sclPinIn};
      sdaSync <= {sdaSync[0], sdaPinIn};
      steSync <= {steSync[0], slaveEnablePinIn};
      // Link reset also zeroes the toggle; flush its echo so no false event
      if (linkReset)
        rxTogSync <= 3'h0;
      else
        rxTogSync <= {rxTogSync[1:0], linkRxToggle};
    end
  end

  assign sclRise = sclSync[1] & ~sclSync[2];
  assign sclFall = ~sclSync[1] & sclSync[2];
  assign sdaBit = sdaSync[1];
  assign steActive = ~steSync[1]; // Enable pin is active low
  assign spiByteDone = rxTogSync[1] ^ rxTogSync[2];
  assign spiMode = ~ctrl.i2cMode;
  // Another master owns the bus: conflict mode with input inactive
  assign masterBlocked = spiMode & ctrl.masterMode & ~ctrl.slaveEnableMode & ~steActive;
  assign unitReset = !resetn || ctrl.softResetBit;

  // Link reset: released only in SPI mode, not blocked, and as a slave only while the enable input is active
  always_ff @(posedge clock)
  begin
    if (!resetn)
      linkReset <= 1'b1;
    else
      linkReset <= ctrl.softResetBit | ctrl.i2cMode | masterBlocked
        | (~ctrl.masterMode & ~steActive);
  end

  scu_link scu_link_inst (
    .linkClock(linkClock),
    .linkReset(linkReset),
    .clockPolaritySelect(ctrl.clockPolaritySelect),
    .clockPhaseSelect(ctrl.clockPhaseSelect),
    .mosi(mosiPin),
    .txWord(txActive),
    .rxWord(linkRxWord),
    .rxToggle(linkRxToggle),
    .misoBit(linkMiso)
  );

  // Output bit is combinational from the shifter so phase 0 has it early
  assign misoPin = linkMiso;

  // Shifter takes a write when idle or when its character just ended empty
  assign txIdle = !unitBusy || (spiByteDone && !txPending);

  // Transmit buffer, busy and completion
  always_ff @(posedge clock)
  begin
    if (unitReset)
    begin
      unitBusy <= 1'b0;
      txPending <= 1'b0;
      txReady <= 1'b1;
      txComplete <= 1'b0;
      txActive <= BYTE_RESET;
      txHold <= BYTE_RESET;
    end
    else if (masterBlocked)
    begin
      // Aborted: data is dropped and must be written again
      unitBusy <= 1'b0;
      txPending <= 1'b0;
      txReady <= 1'b1;
    end
    else
    begin
      if (txWrite && spiMode)
        txComplete <= 1'b0;
      if (spiByteDone && unitBusy)
      begin
        if (txPending)
        begin
          txActive <= txHold;
          txPending <= 1'b0;
          txReady <= 1'b1;
        end
        else
        begin
          // Nothing queued: busy falls once and stays down
          unitBusy <= 1'b0;
          txComplete <= 1'b1;
        end
      end
      if (txWrite && spiMode)
      begin
        if (txIdle)
        begin
          txActive <= transmitBuffer;
          unitBusy <= 1'b1;
        end
        else if (!txPending)
        begin
          // Buffer full is signalled by the ready flag dropping
          txHold <= transmitBuffer;
          txPending <= 1'b1;
          txReady <= 1'b0;
        end
      end
    end
  end

  // Assembled byte on the eighth I2C rise
  assign i2cByte = {i2cShift[BYTE_W-2:0], sdaBit};

  // Receive buffer, I2C shifter and overflow stall
  always_ff @(posedge clock)
  begin
    if (unitReset)
    begin
      receiveBuffer <= BYTE_RESET;
      rxReady <= 1'b0;
      overflow <= 1'b0;
      i2cShift <= BYTE_RESET;
      i2cCount <= I2C_COUNT_RESET;
      loadPending <= 1'b0;
      stretchReq <= 1'b0;
      holdLow <= 1'b0;
    end
    else
    begin
      // Clears first so a same-cycle set wins
      if (rxRead)
        rxReady <= 1'b0;
      if (sclFall)
        loadPending <= 1'b0;
      if (spiMode && spiByteDone)
      begin
        receiveBuffer <= linkRxWord;
        rxReady <= 1'b1;
      end
      if (ctrl.i2cMode && sclRise)
      begin
        if (i2cCount == I2C_ACK_RISE)
          i2cCount <= I2C_COUNT_RESET;
        else
        begin
          i2cShift <= i2cByte;
          i2cCount <= i2cCount + 4'h1;
          if (i2cCount == I2C_LAST_DATA)
          begin
            if (rxWritten)
            begin
              // Previous byte unread: keep this one and stall the bus
              overflow <= 1'b1;
              stretchReq <= 1'b1;
            end
            else
            begin
              receiveBuffer <= i2cByte;
              rxReady <= 1'b1;
              loadPending <= 1'b1;
            end
          end
        end
      end
      // Grab the line only while it is already low
      if (ctrl.i2cMode && sclFall && stretchReq)
      begin
        holdLow <= 1'b1;
        stretchReq <= 1'b0;
      end
      // Unread byte taken: deliver the held one and free the line
      if (holdLow && !rxWritten)
      begin
        receiveBuffer <= i2cShift;
        rxReady <= 1'b1;
        loadPending <= 1'b1;
        holdLow <= 1'b0;
      end
    end
  end

  assign setWritten = ctrl.i2cMode & sclFall & loadPending;

  // Written flag: set wins, the colliding clear is replayed next cycle.
  // The byte was loaded before that fall, so the read already saw it.
  always_ff @(posedge clock)
  begin
    if (unitReset)
    begin
      rxWritten <= 1'b0;
      clearReplay <= 1'b0;
    end
    else
    begin
      clearReplay <= rxRead & setWritten;
      if (setWritten)
        rxWritten <= 1'b1;
      else if (rxRead || clearReplay)
        rxWritten <= 1'b0;
    end
  end

  // Pin drivers and clock request
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      slaveEnablePinOe <= 1'b0;
      slaveEnablePinOut <= 1'b1;
      misoPinOe <= 1'b0;
      sclPinOut <= 1'b0;
      sclPinOe <= 1'b0;
      clockRequest <= 1'b0;
    end
    else
    begin
      slaveEnablePinOe <= spiMode & ctrl.masterMode & ctrl.slaveEnableMode;
      slaveEnablePinOut <= ~unitBusy;
      misoPinOe <= spiMode & ~ctrl.masterMode & steActive & ~ctrl.softResetBit;
      sclPinOut <= 1'b0; // Open drain: only ever pulls low
      sclPinOe <= holdLow;
      // Idle unit stops asking for its clock
      clockRequest <= unitBusy;
    end
  end

  assign status = '{unitBusyFlag: unitBusy, transmitReadyFlag: txReady,
    receiveReadyFlag: rxReady, transmitCompleteFlag: txComplete,
    clockHeldLowStatus: holdLow, overflowFlag: overflow};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (unitReset);

  chk_written_set: assert property (setWritten |=> rxWritten)
    else $error("written flag not set on clock fall");
  chk_read_clears: assert property (rxRead && rxWritten && !setWritten ##1 !setWritten
    |-> !rxWritten)
    else $error("buffer read did not clear written flag");
  chk_collision_replay: assert property (rxRead && setWritten ##1 !setWritten
    |=> !rxWritten)
    else $error("colliding read clear was lost");
  chk_hold_status: assert property (holdLow && rxWritten |=> status.clockHeldLowStatus
    && sclPinOe)
    else $error("clock released while byte unread");
  chk_busy_falls: assert property (spiByteDone && unitBusy && !txPending && !masterBlocked
    && !txWrite |=> !unitBusy ##1 (!unitBusy || $past(txWrite)))
    else $error("busy did not fall after transfer");
  chk_clock_request: assert property ($fell(unitBusy) && !txWrite |=> !clockRequest)
    else $error("clock request kept while idle");
  chk_tx_ready: assert property (txWrite && spiMode && unitBusy && !txPending
    && !spiByteDone && !masterBlocked |=> !status.transmitReadyFlag)
    else $error("transmit ready stayed set with buffer full");
  chk_rx_ready: assert property (spiMode && spiByteDone |=> status.receiveReadyFlag
    && receiveBuffer == $past(linkRxWord))
    else $error("received character not delivered");
  chk_complete_empty: assert property ($rose(txComplete) |-> !$past(txPending))
    else $error("transmit complete raised with data queued");
  chk_enable_out: assert property (spiMode && ctrl.masterMode && ctrl.slaveEnableMode
    && unitBusy |=> slaveEnablePinOe && !slaveEnablePinOut)
    else $error("enable pin not driven while busy");

  cov_spi_byte: cover property (spiMode && spiByteDone && unitBusy);
  cov_i2c_stall: cover property ($rose(holdLow));
  cov_collision: cover property (rxRead && setWritten);
  cov_complete: cover property ($rose(txComplete));

endmodule // scu_top

// ===== verif/scu_spi_peer.sv
`timescale 1ns/1ps
// Behavioural SPI master on the far side of the unit's slave port
module scu_spi_peer (
  input wire logic cpol,
  input wire logic cpha,
  input wire logic misoWire,
  output logic linkClock,
  output logic mosiPin,
  output logic enableN
);
  logic inFrame; // Clock runs only inside a frame
  logic edgeLvl; // Clock level while in a frame
  // Idle level follows polarity, so a slave release always sees it
  assign linkClock = inFrame ? edgeLvl : cpol;
  initial
  begin
    inFrame = 1'b0;
    edgeLvl = 1'b0;
    mosiPin = 1'b0;
    enableN = 1'b1;
  end
  // One 8-bit frame, MSB first, 48 ns link period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    enableN = 1'b0;
    mosiPin = cpha ? ~tx[7] : tx[7];
    edgeLvl = cpol;
    inFrame = 1'b1;
    // Margin lets the slave leave its held reset first
    #48;
    for (i = 7; i >= 0; i--)
    begin
      edgeLvl = ~cpol;
      if (cpha)
        mosiPin = tx[i];
      else
        rx[i] = misoWire;
      #24;
      edgeLvl = cpol;
      if (cpha)
        rx[i] = misoWire;
      else if (i > 0)
        mosiPin = tx[i-1];
      #24;
    end
    inFrame = 1'b0;
    enableN = 1'b1;
    // Released data line shows the inverse, never a stale bit
    mosiPin = ~mosiPin;
  endtask
endmodule // scu_spi_peer

// ===== verif/scu_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("BAD t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
// Self-checking bench: SPI slave traffic, enable pin modes, I2C receive
module scu_top_bench;
  import scu_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  scu_ctrl_t ctrl = '0;
  logic [BYTE_W-1:0] transmitBuffer = BYTE_RESET;
  logic txWrite = 1'b0;
  logic rxRead = 1'b0;
  scu_status_t status;
  logic [BYTE_W-1:0] receiveBuffer;
  logic clockRequest, linkClock, mosiPin, misoPin, misoPinOe, misoWire, enableN;
  logic slaveEnablePinIn, slaveEnablePinOut, slaveEnablePinOe, sclPinOut, sclPinOe;
  logic sclDrv = 1'b1; // Master side of the open-drain clock
  logic sdaDrv = 1'b1;
  logic sclWire;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h8fed_0e60;
  logic [7:0] q[$]; // Expected received characters, oldest first
  logic prevReady = 1'b0;
  logic [7:0] prevBuf = 8'h00;
  logic [7:0] rx, d;
  logic [7:0] expByte; // Oldest note, taken once per character
  int k;
  always #2.5 clock = ~clock;
  // Wires resolved from every party's enable
  assign sclWire = sclDrv & ~(sclPinOe & ~sclPinOut);
  assign slaveEnablePinIn = slaveEnablePinOe ? slaveEnablePinOut : enableN;
  assign misoWire = misoPinOe ? misoPin : 1'bz;
  scu_top scu_top_inst (.clock(clock), .resetn(resetn), .ctrl(ctrl),
    .transmitBuffer(transmitBuffer), .txWrite(txWrite), .rxRead(rxRead),
    .status(status), .receiveBuffer(receiveBuffer), .clockRequest(clockRequest),
    .linkClock(linkClock), .mosiPin(mosiPin), .misoPin(misoPin), .misoPinOe(misoPinOe),
    .slaveEnablePinIn(slaveEnablePinIn), .slaveEnablePinOut(slaveEnablePinOut),
    .slaveEnablePinOe(slaveEnablePinOe), .sclPinIn(sclWire), .sdaPinIn(sdaDrv),
    .sclPinOut(sclPinOut), .sclPinOe(sclPinOe));
  scu_spi_peer scu_spi_peer_inst (.cpol(ctrl.clockPolaritySelect),
    .cpha(ctrl.clockPhaseSelect), .misoWire(misoWire), .linkClock(linkClock),
    .mosiPin(mosiPin), .enableN(enableN));
  // Xorshift source for data bytes
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic set_ctrl(input scu_ctrl_t c);
    @(posedge clock);
    ctrl <= c;
    tick(4);
  endtask
  task automatic pulse_wr(input logic [7:0] v);
    @(posedge clock);
    transmitBuffer <= v;
    txWrite <= 1'b1;
    @(posedge clock);
    txWrite <= 1'b0;
  endtask
  task automatic pulse_rd;
    @(posedge clock);
    rxRead <= 1'b1;
    @(posedge clock);
    rxRead <= 1'b0;
  endtask
  // Bounded wait for the busy bit to fall
  task automatic wait_idle;
    int n;
    n = 0;
    while (status.unitBusyFlag !== 1'b0 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
  endtask
  // Slave transfer of n bytes back to back in one polarity/phase setting
  task automatic spi_case(input logic cpol, input logic cpha, input int n);
    scu_ctrl_t c;
    logic [7:0] txs [2];
    c = '0;
    c.clockPolaritySelect = cpol;
    c.clockPhaseSelect = cpha;
    c.softResetBit = 1'b1;
    set_ctrl(c);
    c.softResetBit = 1'b0;
    set_ctrl(c);
    seed = xs(seed);
    for (k = 0; k < n; k++)
    begin
      txs[k] = seed[8*k +: 8];
      pulse_wr(txs[k]);
    end
    tick(2);
    `CHK(status.unitBusyFlag, 1'b1)
    `CHK(clockRequest, 1'b1)
    `CHK(status.transmitReadyFlag, n == 1)
    for (k = 0; k < n; k++)
    begin
      d = seed[23:16] ^ {8{k[0]}};
      q.push_back(d);
      scu_spi_peer_inst.xfer(d, rx);
      `CHK(rx, txs[k])
      tick(8);
      pulse_rd;
    end
    wait_idle;
    `CHK(status.transmitCompleteFlag, 1'b1)
    tick(2);
    `CHK(clockRequest, 1'b0)
    tick(20);
    `CHK(status.unitBusyFlag, 1'b0)
  endtask
  // One I2C byte plus acknowledge clock; optional read after the 8th fall
  task automatic i2c_byte(input logic [7:0] v, input int rdAt);
    int i;
    for (i = 8; i >= 0; i--)
    begin
      @(posedge clock);
      sdaDrv <= (i > 0) ? v[i-1] : 1'b1;
      tick(4);
      sclDrv <= 1'b1;
      tick(8);
      sclDrv <= 1'b0;
      if (i == 1 && rdAt >= 0)
      begin
        tick(rdAt);
        pulse_rd;
      end
      tick(4);
    end
  endtask
  // Takes the oldest note whenever a new character shows
  always @(posedge clock)
  begin
    if (resetn && status.receiveReadyFlag === 1'b1 &&
        (prevReady !== 1'b1 || receiveBuffer !== prevBuf))
    begin
      expByte = (q.size() > 0) ? q.pop_front() : ~receiveBuffer;
      `CHK(receiveBuffer, expByte)
    end
    prevReady <= status.receiveReadyFlag;
    prevBuf <= receiveBuffer;
  end
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test;
    end
  end
  initial
  begin
    scu_ctrl_t c;
    int j;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    tick(2);
    `CHK(status, 6'h10)
    for (j = 0; j < 4; j++)
      spi_case(j[1], j[0], (j == 0) ? 2 : 1);
    c = '0;
    c.masterMode = 1'b1;
    c.slaveEnableMode = 1'b1;
    set_ctrl(c);
    `CHK(slaveEnablePinOe, 1'b1)
    pulse_wr(8'h5a);
    tick(2);
    `CHK(slaveEnablePinOut, 1'b0)
    c.softResetBit = 1'b1;
    set_ctrl(c);
    `CHK(status.unitBusyFlag, 1'b0)
    `CHK(clockRequest, 1'b0)
    c.softResetBit = 1'b0;
    c.slaveEnableMode = 1'b0;
    set_ctrl(c);
    `CHK(slaveEnablePinOe, 1'b0)
    pulse_wr(8'ha5);
    tick(2);
    `CHK(status.unitBusyFlag, 1'b0)
    c = '0;
    c.i2cMode = 1'b1;
    c.softResetBit = 1'b1;
    sclDrv <= 1'b0;
    set_ctrl(c);
    c.softResetBit = 1'b0;
    set_ctrl(c);
    // Reads swept across the flag-set cycle; a lost clear stalls later
    // A read before the flag sets would leave it set, so sweep from the set cycle
    for (j = 1; j < 8; j++)
    begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      i2c_byte(seed[7:0], j);
    end
    `CHK(status.overflowFlag, 1'b0)
    `CHK(sclPinOe, 1'b0)
    d = seed[15:8];
    q.push_back(d);
    q.push_back(~d);
    i2c_byte(d, -1);
    i2c_byte(~d, -1);
    tick(40);
    `CHK(sclPinOe, 1'b1)
    `CHK(status.clockHeldLowStatus, 1'b1)
    `CHK(status.overflowFlag, 1'b1)
    pulse_rd;
    tick(3);
    `CHK(sclPinOe, 1'b0)
    pulse_rd;
    tick(4);
    `CHK(q.size(), 0)
    finish_test;
  end
endmodule // scu_top_bench
